// ===== hdl/efs_pkg.sv
// Purpose: Shared constants and types for the E1 receive frame sync monitor
// Assumes: 256-bit E1 basic frames of 125 us; bit 1 of each timeslot arrives first
// Notes:   Timer lengths are counted in received basic frames, not in clock cycles
package efs_pkg;
  localparam int FRAME_US  = 125;
  localparam int T8_MS     = 8;
  localparam int T10_MS    = 10;
  localparam int T400_MS   = 400;
  localparam int T1S_MS    = 1000;
  localparam int FR_8MS    = T8_MS * 1000 / FRAME_US;
  localparam int FR_10MS   = T10_MS * 1000 / FRAME_US;
  localparam int FR_400MS  = T400_MS * 1000 / FRAME_US;
  localparam int FR_1S     = T1S_MS * 1000 / FRAME_US;

  localparam logic [7:0] TS0_END   = 8'h07;
  localparam logic [7:0] TS16_END  = 8'h87;
  localparam logic [7:0] FRAME_END = 8'hff;
  localparam logic [6:0] FAS_WORD  = 7'h1b;
  localparam logic [5:0] MFAS_WORD = 6'h0b;
  localparam logic [3:0] SMFAS_NIB = 4'h0;
  localparam logic [3:0] MFAS_LAST = 4'hb;
  localparam logic [3:0] E1_FRAME  = 4'hd;
  localparam logic [3:0] E2_FRAME  = 4'hf;
  localparam logic [2:0] SMF_LAST  = 3'h7;
  localparam logic [3:0] GAP_2MS   = 4'h0;
  localparam logic [1:0] LOSS_RUN  = 2'h3;
  localparam logic [9:0] EXCESS_CRC = 10'h393;
  localparam logic [9:0] FEBE_SEC_MIN = 10'h3de;
  localparam logic [3:0] CAS_FRAME0 = 4'h0;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FLAGS  = 8'h08;
  localparam logic [7:0] REG_ENABLE = 8'h0c;

  localparam int CTL_CRC_EN   = 0;
  localparam int CTL_CAS_EN   = 1;
  localparam int CTL_KEEP     = 2;
  localparam int CTL_WORD_SEL = 3;
  localparam int CTL_NFAS_CNT = 4;
  localparam int CTL_NFAS_LOS = 5;
  localparam int CTL_AUTO_REF = 6;
  localparam int CTL_CRC_REF  = 7;
  localparam int CTL_MAN_REF  = 8;
  localparam int CTL_W        = 9;
  localparam logic [CTL_W-1:0] CTRL_RST = 9'h043;
  localparam logic [31:0] ENABLE_RST = 32'h0000_0000;

  localparam int EV_FER = 0;
  localparam int EV_MFAS = 1;
  localparam int EV_CRC = 2;
  localparam int EV_EXC = 3;
  localparam int EV_SMFAS = 4;
  localparam int EV_FEBE = 5;
  localparam int EV_NTFEBE = 6;
  localparam int EV_NTCRC = 7;
  localparam int EV_COFA = 8;
  localparam int NUM_EV = 9;
  localparam int NUM_ST = 7;

  typedef enum logic [2:0] {
    EFS_HUNT,
    EFS_STEP2,
    EFS_SKIP,
    EFS_STEP3,
    EFS_SYNC,
    EFS_HOLD
  } efs_fstate_t;
endpackage : efs_pkg

// ===== hdl/efs_frame_sync_monitor.sv
// Purpose: E1 receive basic frame, CRC-4 multiframe and CAS multiframe alignment with error monitoring
// Assumes: rx_bit_in/rx_bit_valid_in come from the line side and are resynchronised here
// Notes:   APB slave, no wait states; ready in the first access cycle
`timescale 1ns/10ps
module efs_frame_sync_monitor #(
  parameter int T8_FRAMES   = efs_pkg::FR_8MS,
  parameter int T10_FRAMES  = efs_pkg::FR_10MS,
  parameter int T400_FRAMES = efs_pkg::FR_400MS,
  parameter int T1S_FRAMES  = efs_pkg::FR_1S
) (
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  input  wire logic        rx_bit_in,
  input  wire logic        rx_bit_valid_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             irq_out,
  output logic [efs_pkg::NUM_EV-1:0] pm_event_out,
  output logic [2:0]       pm_fer_count_out
);
  import efs_pkg::*;

  logic              rx_s1, rx_s2, vl_s1, vl_s2;
  logic [7:0]        sr, bit_cnt, free_cnt, align_pos;
  efs_fstate_t       fstate, next_fstate;
  logic              fas_frame, have_pos;
  logic [1:0]        fas_run, nfas_run;
  logic [CTL_W-1:0]  ctrl;
  logic              manual_reframe_d;
  logic [31:0]       flags, enable;
  logic [NUM_ST-1:0] st_prev;
  logic              crc_loss, offline, iw, have_hit;
  logic [15:0]       t8, t400, sec_cnt, ab_cnt;
  logic [7:0]        gap;
  logic [5:0]        si_hist;
  logic [3:0]        mf_cnt, crc, crc_ref, c_rx, sa6;
  logic              ref_valid;
  logic [9:0]        crc_cnt, febe_cnt;
  logic [3:0]        sec_hist;
  logic              a_bit, e_zero, ab_stat, cb_stat;
  logic              smf_loss, y_bit;
  logic [3:0]        prev_nib, sfc;
  logic [2:0]        fas_nbits;

  // Line pins cross into this clock through two flops
  always_ff @(posedge sys_clk_in) begin
    rx_s1 <= rx_bit_in;
    rx_s2 <= rx_s1;
    vl_s1 <= rx_bit_valid_in;
    vl_s2 <= vl_s1;
  end

  wire       bit_ok    = vl_s2;
  wire [7:0] next_sr   = {sr[6:0], rx_s2};
  wire       ts0_end   = bit_ok & (bit_cnt == TS0_END);
  wire       ts16_end  = bit_ok & (bit_cnt == TS16_END);
  wire       frame_end = bit_ok & (bit_cnt == FRAME_END);
  wire [6:0] fas_diff  = next_sr[6:0] ^ FAS_WORD;
  wire       fas_match = (fas_diff == 7'h00);
  wire       in_sync   = (fstate == EFS_SYNC);
  wire       si_bit    = next_sr[7];
  wire       crc_en    = ctrl[CTL_CRC_EN];
  wire       cas_en    = ctrl[CTL_CAS_EN];
  wire       manual_reframe_rise = ctrl[CTL_MAN_REF] & ~manual_reframe_d;
  wire       crc_ok    = in_sync & ~crc_loss;
  wire       smf_end   = frame_end & (mf_cnt[2:0] == SMF_LAST);

  // Framing errors
  always_comb begin
    fas_nbits = 3'h0;
    for (int i = 0; i < 7; i++) begin
      fas_nbits = fas_nbits + {2'b00, fas_diff[i]};
    end
  end
  wire       fas_err  = in_sync & ts0_end & fas_frame & ~fas_match;
  wire       nfas_err = in_sync & ts0_end & ~fas_frame & ~next_sr[6];
  wire       fer_on   = in_sync & ~(crc_en & crc_loss);
  wire [2:0] fer_fas  = ctrl[CTL_WORD_SEL] ? {2'b00, fas_err} : (fas_err ? fas_nbits : 3'h0);
  wire [2:0] fer_nfas = {2'b00, nfas_err & ctrl[CTL_NFAS_CNT]};
  wire [2:0] fer_cnt  = fer_on ? fer_fas + fer_nfas : 3'h0;
  wire       loss_fas = fas_err & (fas_run == LOSS_RUN - 2'h1);
  wire       loss_nfas = nfas_err & ctrl[CTL_NFAS_LOS] & (nfas_run == LOSS_RUN - 2'h1);

  // CRC multiframe search and checks
  wire [5:0] si_now     = {si_hist[4:0], si_bit};
  wire       crc_search = in_sync & crc_en & crc_loss & (~iw | ctrl[CTL_KEEP]) & ~offline;
  wire       odd_ts0    = ts0_end & ~fas_frame;
  wire       mfas_hit   = crc_search & odd_ts0 & (si_now == MFAS_WORD);
  wire       mf_lock    = mfas_hit & have_hit & (gap[3:0] == GAP_2MS) & (gap != 8'h00);
  wire       t8_exp     = crc_search & frame_end & (t8 == 16'(T8_FRAMES - 1));
  wire       off_found  = offline & bit_ok & fas_match & (bit_cnt != TS0_END);
  wire       sec_end    = frame_end & (sec_cnt == 16'(T1S_FRAMES - 1));
  wire       crc_in     = ((bit_cnt == 8'h00) & fas_frame) ? 1'b0 : rx_s2;
  wire       crc_fb     = crc[3] ^ crc_in;
  wire [3:0] next_crc   = {crc[2:0], 1'b0} ^ {2'b00, crc_fb, crc_fb};
  wire       e_frame    = (mf_cnt == E1_FRAME) | (mf_cnt == E2_FRAME);
  wire       febe_now   = crc_ok & odd_ts0 & e_frame & ~si_bit;
  wire       ab_cond    = crc_ok & a_bit & e_zero;
  wire       good_sec   = (febe_cnt >= FEBE_SEC_MIN);

  // Signalling multiframe
  wire [3:0] nib        = next_sr[7:4];
  wire       smf_hit    = in_sync & cas_en & smf_loss & ts16_end & (nib == SMFAS_NIB) & (prev_nib != 4'h0);

  logic [NUM_EV-1:0] ev;
  always_comb begin
    ev = '0;
    ev[EV_FER]    = (fer_cnt != 3'h0);
    ev[EV_MFAS]   = crc_ok & odd_ts0 & (mf_cnt == MFAS_LAST) & (si_now != MFAS_WORD);
    ev[EV_CRC]    = crc_ok & smf_end & ref_valid & (c_rx != crc_ref);
    ev[EV_EXC]    = ev[EV_CRC] & (crc_cnt == EXCESS_CRC - 10'h001);
    ev[EV_SMFAS]  = in_sync & ~smf_loss & ts16_end & (sfc == CAS_FRAME0) & (nib != SMFAS_NIB);
    ev[EV_FEBE]   = febe_now;
    ev[EV_NTFEBE] = crc_ok & smf_end & ((sa6 == 4'h1) | (sa6 == 4'h3));
    ev[EV_NTCRC]  = crc_ok & smf_end & ((sa6 == 4'h2) | (sa6 == 4'h3));
    ev[EV_COFA]   = (fstate == EFS_STEP3) & ts0_end & fas_match & have_pos & (free_cnt != align_pos);
  end

  // Basic frame state machine
  always_comb begin
    next_fstate = fstate;
    unique case (fstate)
      EFS_HUNT:  if (bit_ok & fas_match) next_fstate = EFS_STEP2;
      EFS_STEP2: if (ts0_end) next_fstate = next_sr[6] ? EFS_STEP3 : EFS_SKIP;
      EFS_SKIP:  if (ts0_end) next_fstate = EFS_HUNT;
      EFS_STEP3: if (ts0_end) next_fstate = fas_match ? EFS_SYNC : EFS_HUNT;
      EFS_SYNC: begin
        if (loss_fas | loss_nfas) next_fstate = ctrl[CTL_AUTO_REF] ? EFS_HUNT : EFS_HOLD;
        else if (ev[EV_EXC]) next_fstate = (ctrl[CTL_AUTO_REF] & ctrl[CTL_CRC_REF]) ? EFS_HUNT : EFS_HOLD;
      end
      EFS_HOLD:  next_fstate = EFS_HOLD;
    endcase
    if (manual_reframe_rise) next_fstate = EFS_HUNT;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      fstate   <= EFS_HUNT;
      sr       <= 8'h00;
      bit_cnt  <= 8'h00;
      free_cnt <= 8'h00;
      fas_frame <= 1'b0;
    end else begin
      fstate <= next_fstate;
      if (bit_ok) sr <= next_sr;
      if (bit_ok) free_cnt <= free_cnt + 8'h01;
      if ((fstate == EFS_HUNT) & bit_ok & fas_match) begin
        bit_cnt   <= TS0_END + 8'h01;
        fas_frame <= 1'b1;
      end else if (bit_ok) begin
        bit_cnt <= bit_cnt + 8'h01;
        if (frame_end) fas_frame <= ~fas_frame;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in | ~in_sync) begin
      fas_run  <= 2'h0;
      nfas_run <= 2'h0;
    end else if (ts0_end) begin
      if (fas_frame) fas_run <= fas_err ? fas_run + 2'h1 : 2'h0;
      else nfas_run <= nfas_err ? nfas_run + 2'h1 : 2'h0;
    end
  end

  // Alignment position for change detection
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      have_pos  <= 1'b0;
      align_pos <= 8'h00;
    end else if ((fstate == EFS_STEP3) & ts0_end & fas_match) begin
      have_pos  <= 1'b1;
      align_pos <= free_cnt;
    end
  end

  // CRC multiframe search, timers, interworking
  always_ff @(posedge sys_clk_in) begin
    if (srst_in | ~in_sync | ~crc_en) begin
      crc_loss <= 1'b1;
      offline  <= 1'b0;
      iw       <= 1'b0;
      have_hit <= 1'b0;
      t8       <= 16'h0000;
      t400     <= 16'h0000;
      gap      <= 8'h00;
    end else begin
      if (frame_end & (gap != 8'hff)) gap <= gap + 8'h01;
      if (mf_lock) crc_loss <= 1'b0;
      if (mfas_hit) begin
        have_hit <= 1'b1;
        gap      <= 8'h00;
      end
      if (t8_exp) begin
        offline  <= 1'b1;
        have_hit <= 1'b0;
      end else if (off_found) begin
        offline  <= 1'b0;
        t8       <= 16'h0000;
        have_hit <= 1'b0;
      end else if (crc_search & frame_end) t8 <= t8 + 16'h0001;
      if (crc_loss & ~iw & frame_end) begin
        if (t400 == 16'(T400_FRAMES - 1)) iw <= 1'b1;
        else t400 <= t400 + 16'h0001;
      end
      if (~crc_loss) iw <= 1'b0;
    end
  end

  // Frame numbering, CRC-4, Si and Sa6 capture
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      mf_cnt <= 4'h0;
      si_hist <= 6'h00;
      crc <= 4'h0;
      crc_ref <= 4'h0;
      c_rx <= 4'h0;
      sa6 <= 4'h0;
      ref_valid <= 1'b0;
      a_bit <= 1'b0;
      e_zero <= 1'b0;
    end else begin
      if (mfas_hit) mf_cnt <= MFAS_LAST;
      else if (frame_end) mf_cnt <= mf_cnt + 4'h1;
      if (odd_ts0) begin
        si_hist <= si_now;
        sa6     <= {sa6[2:0], next_sr[2]};
        a_bit   <= next_sr[5];
      end
      if (ts0_end & fas_frame) c_rx <= {c_rx[2:0], si_bit};
      if (crc_ok & odd_ts0 & e_frame) e_zero <= ~si_bit;
      if (smf_end) begin
        crc       <= 4'h0;
        crc_ref   <= next_crc;
        ref_valid <= crc_ok;
      end else if (bit_ok) crc <= next_crc;
      if (~crc_ok) ref_valid <= 1'b0;
    end
  end

  // One-second windows, excessive CRC, continuous block errors
  always_ff @(posedge sys_clk_in) begin
    if (srst_in | ~crc_ok) begin
      sec_cnt  <= 16'h0000;
      crc_cnt  <= 10'h000;
      febe_cnt <= 10'h000;
      sec_hist <= 4'h0;
      cb_stat  <= 1'b0;
    end else if (sec_end) begin
      sec_cnt  <= 16'h0000;
      crc_cnt  <= 10'h000;
      febe_cnt <= 10'h000;
      sec_hist <= {sec_hist[2:0], good_sec};
      cb_stat  <= &{sec_hist, good_sec};
    end else begin
      if (frame_end) sec_cnt <= sec_cnt + 16'h0001;
      if (ev[EV_CRC] & (crc_cnt != 10'h3ff)) crc_cnt <= crc_cnt + 10'h001;
      if (febe_now & (febe_cnt != 10'h3ff)) febe_cnt <= febe_cnt + 10'h001;
    end
  end

  // Alarm bit with E zero held for the interval; drops at once when it stops
  always_ff @(posedge sys_clk_in) begin
    if (srst_in | ~ab_cond) begin
      ab_cnt  <= 16'h0000;
      ab_stat <= 1'b0;
    end else if (frame_end) begin
      if (ab_cnt == 16'(T10_FRAMES - 1)) ab_stat <= 1'b1;
      else ab_cnt <= ab_cnt + 16'h0001;
    end
  end

  // Signalling multiframe
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      smf_loss <= 1'b1;
      prev_nib <= 4'h0;
      sfc      <= 4'h0;
      y_bit    <= 1'b0;
    end else begin
      if (ts16_end) prev_nib <= nib;
      if (smf_hit) sfc <= CAS_FRAME0;
      else if (frame_end) sfc <= sfc + 4'h1;
      if (~in_sync | ~cas_en) smf_loss <= 1'b1;
      else if (smf_hit) smf_loss <= 1'b0;
      if (in_sync & ~smf_loss & ts16_end & (sfc == CAS_FRAME0)) y_bit <= next_sr[2];
    end
  end

  // Register bus
  wire [NUM_ST-1:0] st = {cb_stat, ab_stat, iw, offline, smf_loss, crc_loss, ~in_sync};
  wire              setup    = psel_in & ~penable_in;
  wire              access   = psel_in & penable_in & pready_out;
  wire              hit_ctrl = (paddr_in == REG_CTRL);
  wire              hit_stat = (paddr_in == REG_STATUS);
  wire              hit_flag = (paddr_in == REG_FLAGS);
  wire              hit_en   = (paddr_in == REG_ENABLE);
  wire              addr_ok  = hit_ctrl | hit_stat | hit_flag | hit_en;
  wire              wr       = access & pwrite_in;
  wire [31:0]       flag_clr = (wr & hit_flag) ? pwdata_in : 32'h0000_0000;
  wire [31:0]       flag_set = {9'h000, st ^ st_prev, 7'h00, ev};
  wire [31:0]       next_flags = (flags & ~flag_clr) | flag_set;
  wire [31:0]       rd_mux   = hit_ctrl ? {23'h000000, ctrl} :
                               hit_stat ? {23'h000000, y_bit, a_bit, st} :
                               hit_flag ? flags :
                               hit_en   ? enable : 32'h0000_0000;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ctrl    <= CTRL_RST;
      enable  <= ENABLE_RST;
      manual_reframe_d  <= 1'b0;
      flags   <= 32'h0000_0000;
      st_prev <= '1;
    end else begin
      if (wr & hit_ctrl) ctrl <= pwdata_in[CTL_W-1:0];
      if (wr & hit_en) enable <= pwdata_in;
      manual_reframe_d  <= ctrl[CTL_MAN_REF];
      flags   <= next_flags;
      st_prev <= st;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      prdata_out       <= 32'h0000_0000;
      pready_out       <= 1'b0;
      pslverr_out      <= 1'b0;
      irq_out          <= 1'b0;
      pm_event_out     <= '0;
      pm_fer_count_out <= 3'h0;
    end else begin
      prdata_out       <= setup ? rd_mux : 32'h0000_0000;
      pready_out       <= setup;
      pslverr_out      <= setup & ~addr_ok;
      irq_out          <= |(next_flags & enable);
      pm_event_out     <= ev;
      pm_fer_count_out <= fer_cnt;
    end
  end
endmodule : efs_frame_sync_monitor

// ===== tb/efs_sync_properties.sv
// Purpose: Port-level properties of the E1 frame sync monitor
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound into the top module; sees its ports only
`timescale 1ns/10ps
module efs_sync_properties (
  input wire logic                       sys_clk_in,
  input wire logic                       srst_in,
  input wire logic                       rx_bit_valid_in,
  input wire logic                       psel_in,
  input wire logic                       penable_in,
  input wire logic                       pwrite_in,
  input wire logic [7:0]                 paddr_in,
  input wire logic [31:0]                prdata_out,
  input wire logic                       pready_out,
  input wire logic                       pslverr_out,
  input wire logic                       irq_out,
  input wire logic [efs_pkg::NUM_EV-1:0] pm_event_out,
  input wire logic [2:0]                 pm_fer_count_out
);
  import efs_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  wire setup  = psel_in && !penable_in;
  wire mapped = paddr_in inside {REG_CTRL, REG_STATUS, REG_FLAGS, REG_ENABLE};
  property p_answer; setup |=> pready_out ##1 !pready_out; endproperty
  a_answer: assert property (p_answer) else $error("ready not one cycle after setup");
  property p_unmapped; setup && !mapped |=> pslverr_out && prdata_out == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_idle; !pready_out |-> prdata_out == 32'h0 && !pslverr_out; endproperty
  a_idle: assert property (p_idle) else $error("read bus not quiet when idle");
  property p_ctrl; setup && !pwrite_in && paddr_in == REG_CTRL |=> prdata_out[31:CTL_W] == '0; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control read shows unused bits");
  property p_fer; pm_event_out[EV_FER] == (pm_fer_count_out != 3'h0); endproperty
  a_fer: assert property (p_fer) else $error("framing count and pulse disagree");
  property p_pulse; (pm_event_out & $past(pm_event_out)) == '0; endproperty
  a_pulse: assert property (p_pulse) else $error("event pulse longer than one cycle");
  property p_cause; pm_event_out != '0 |-> $past(rx_bit_valid_in, 3); endproperty
  a_cause: assert property (p_cause) else $error("event without a deciding bit");
  property p_reset; disable iff (1'b0) srst_in |=> pm_event_out == '0 && !irq_out && !pready_out; endproperty
  a_reset: assert property (p_reset) else $error("outputs active after reset");
  c_fer: cover property (pm_event_out[EV_FER]);
  c_febe: cover property (pm_event_out[EV_FEBE]);
  c_err: cover property (pready_out && pslverr_out);
endmodule : efs_sync_properties
bind efs_frame_sync_monitor efs_sync_properties props_u (.sys_clk_in, .srst_in, .rx_bit_valid_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out, .irq_out, .pm_event_out,
  .pm_fer_count_out);

// ===== tb/efs_line_model.sv
// Purpose: Remote E1 line end sending framed PCM bits
// Assumes: One bit a clock, or one every other clock while slow_in is high
// Notes:   CRC bits go out as ones, so CRC-4 errors are expected
`timescale 1ns/10ps
module efs_line_model (
  input  wire logic clk_in,
  input  wire logic slow_in,
  input  wire logic fas_err_in,
  input  wire logic nfas_err_in,
  input  wire logic mfas_err_in,
  input  wire logic e_zero_in,
  input  wire logic alarm_in,
  output logic      bit_out = 1'b1,
  output logic      valid_out = 1'b0,
  output logic      frame_start_out = 1'b0
);
  import efs_pkg::*;
  logic [7:0] bit_cnt = 8'h00;
  logic [3:0] mf_cnt  = 4'h0;
  logic [7:0] shift   = 8'hff;
  logic       gap     = 1'b0;
  logic       si;
  logic [7:0] ts0;
  logic [7:0] next_byte;
  assign si = !mf_cnt[0] ? 1'b1 : (mf_cnt > MFAS_LAST) ? !e_zero_in :
              MFAS_WORD[3'd5 - mf_cnt[3:1]] ^ (mfas_err_in && mf_cnt == 4'h1);
  assign ts0 = mf_cnt[0] ? {si, !nfas_err_in, alarm_in, 5'h1f}
             : {si, FAS_WORD ^ {5'h00, fas_err_in, fas_err_in}};
  // Only frame 0 carries the zero nibble, so the previous nibble is never zero
  assign next_byte = (bit_cnt == 8'h00) ? ts0 : (bit_cnt == 8'h80 && mf_cnt == CAS_FRAME0) ? 8'h0b : 8'hff;
  always @(posedge clk_in) begin
    if (slow_in && !gap) begin
      gap             <= 1'b1;
      valid_out       <= 1'b0;
      frame_start_out <= 1'b0;
      bit_out         <= ~bit_out;
    end else begin
      gap             <= 1'b0;
      valid_out       <= 1'b1;
      frame_start_out <= (bit_cnt == 8'h00);
      bit_out         <= (bit_cnt[2:0] == 3'h0) ? next_byte[7] : shift[7];
      shift           <= (bit_cnt[2:0] == 3'h0) ? {next_byte[6:0], 1'b0} : {shift[6:0], 1'b0};
      bit_cnt         <= bit_cnt + 8'h01;
      mf_cnt          <= (bit_cnt == FRAME_END) ? mf_cnt + 4'h1 : mf_cnt;
    end
  end
endmodule : efs_line_model

// ===== tb/e1_frame_sync_monitor_bench.sv
// Purpose: Self-checking bench for the E1 frame sync monitor
// Assumes: Timers shortened through parameters
// Notes:   CRC-4 error flag is masked since the line model sends no real CRC
`timescale 1ns/10ps
module e1_frame_sync_monitor_bench;
  import efs_pkg::*;
  logic              clk = 1'b0, rst = 1'b1, bit_w, valid_w, fstart, pready, pslverr, irq, err;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic              fas_e = 1'b0, nfas_e = 1'b0, mfas_e = 1'b0, e_zero = 1'b0, alarm = 1'b0, slow = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0, prdata, q;
  logic [NUM_EV-1:0] ev;
  logic [2:0]        fer;
  int                fail_count = 0, checks = 0, fer_sum = 0, base;
  always #2.5 clk = ~clk;
  always @(posedge clk) fer_sum <= fer_sum + int'(fer);
  efs_frame_sync_monitor #(.T8_FRAMES(48), .T10_FRAMES(20), .T400_FRAMES(64), .T1S_FRAMES(50)) dut_u (
    .sys_clk_in(clk), .srst_in(rst), .rx_bit_in(bit_w), .rx_bit_valid_in(valid_w), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq), .pm_event_out(ev), .pm_fer_count_out(fer));
  efs_line_model line_u (.clk_in(clk), .slow_in(slow), .fas_err_in(fas_e), .nfas_err_in(nfas_e),
    .mfas_err_in(mfas_e), .e_zero_in(e_zero), .alarm_in(alarm), .bit_out(bit_w), .valid_out(valid_w),
    .frame_start_out(fstart));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // An idle edge first, so psel is never assigned twice in one time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q   = prdata;
    err = pslverr;
    if (pready !== 1'b1) fail_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_frames(input int n);
    repeat (n) begin
      do @(posedge clk); while (fstart !== 1'b1);
    end
  endtask : wait_frames
  task automatic end_of_test();
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, REG_CTRL, 32'h0);
    check(q, {23'h0, CTRL_RST});
    apb(1'b0, REG_ENABLE, 32'h0);
    check(q, ENABLE_RST);
    apb(1'b0, REG_STATUS, 32'h0);
    check(q & 32'h7f, 32'h07);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    check({31'h0, err}, 32'h1);
    wait_frames(48);
    apb(1'b0, REG_STATUS, 32'h0);
    check(q & 32'h1ff, 32'h0);
    apb(1'b1, REG_FLAGS, 32'hffff_ffff);
    apb(1'b0, REG_FLAGS, 32'h0);
    check(q & ~32'h4, 32'h0);
    e_zero <= 1'b1;
    alarm  <= 1'b1;
    wait_frames(40);
    apb(1'b0, REG_STATUS, 32'h0);
    check(q & 32'ha0, 32'ha0);
    apb(1'b1, REG_ENABLE, 32'h20);
    apb(1'b0, REG_FLAGS, 32'h0);
    check(q & 32'h21, 32'h20);
    check({31'h0, irq}, 32'h1);
    e_zero <= 1'b0;
    alarm  <= 1'b0;
    wait_frames(16);
    apb(1'b1, REG_FLAGS, 32'h20);
    apb(1'b0, REG_STATUS, 32'h0);
    check(q & 32'ha0, 32'h0);
    check({31'h0, irq}, 32'h0);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, REG_CTRL, 32'h043 | (m << 3));
      base = fer_sum;
      wait_frames(1);
      fas_e  <= 1'b1;
      nfas_e <= 1'b1;
      wait_frames(2);
      fas_e  <= 1'b0;
      nfas_e <= 1'b0;
      wait_frames(2);
      check(32'(fer_sum - base), (m[0] ? 32'h1 : 32'h2) + (m[1] ? 32'h1 : 32'h0));
    end
    apb(1'b1, REG_CTRL, 32'h043);
    apb(1'b1, REG_FLAGS, 32'hffff_ffff);
    wait_frames(1);
    slow   <= 1'b1;
    mfas_e <= 1'b1;
    wait_frames(16);
    mfas_e <= 1'b0;
    wait_frames(4);
    slow <= 1'b0;
    apb(1'b0, REG_FLAGS, 32'h0);
    check(q & 32'h3, 32'h2);
    fas_e <= 1'b1;
    wait_frames(8);
    apb(1'b0, REG_STATUS, 32'h0);
    check(q & 32'h7, 32'h7);
    fas_e <= 1'b0;
    apb(1'b1, REG_FLAGS, 32'hffff_ffff);
    wait_frames(56);
    apb(1'b0, REG_STATUS, 32'h0);
    check(q & 32'h7, 32'h0);
    apb(1'b0, REG_FLAGS, 32'h0);
    check(q & 32'h101, 32'h0);
    apb(1'b1, REG_CTRL, 32'h023);
    nfas_e <= 1'b1;
    wait_frames(8);
    nfas_e <= 1'b0;
    mfas_e <= 1'b1;
    wait_frames(8);
    apb(1'b0, REG_STATUS, 32'h0);
    check(q & 32'h1, 32'h1);
    apb(1'b1, REG_CTRL, 32'h123);
    wait_frames(80);
    apb(1'b0, REG_STATUS, 32'h0);
    check(q & 32'h13, 32'h12);
    end_of_test();
  end
endmodule : e1_frame_sync_monitor_bench
